// ==== hdl/pam_params.svh ====
// constants of the port a low pin function select block
// assumes a 16-bit register image behind a 32-bit avalon-mm word slave
//
// How it works
// - pin 10 codes: 000 gpio, 001 chip select, 010 read strobe, 100 test clock, 101 clock2
// - pin 9 codes: 000 gpio, 001 timer clock d, 010 interrupt 3, 101 serial3 transmit
// - pin 8 codes: 000 gpio, 001 timer clock c, 010 interrupt 2, 101 serial3 receive
// - pin 7 codes: 000 gpio, 001 timer clock b, 011 bus wait, 101 serial2 transmit
// - pin 6 codes: 000 gpio, 001 timer clock a, 011 read strobe, 101 serial2 receive
// - pin 5 codes: 000 gpio, 011 interrupt 1, 100 address 5, 101 disable 6, 110 clock3
// - pin 4 codes: 000 gpio, 100 address 4, 101 disable 5, 110 serial3 transmit
// - pin 3 codes: 000 gpio, 100 address 3, 101 disable 4, 110 serial3 receive
// - pin 1 codes: 000 gpio, 100 address 1, 101 disable 1, 110 serial2 transmit
// - pin 0 codes: 000 gpio, 100 address 0, 101 disable 0, 110 serial2 receive
// - debug pin low at reset sets pin 10 top mode bit
// - rom-off 8-bit mode resets pin 6 low bits and pins 5..0 top bits to one
// - otherwise all fields reset to zero, gpio; all fields read and write
// - gpio, serial clock and motor pulse drive when the direction bit is one
// - the three select registers are 16 bits, read and write
`ifndef PAM_PARAMS_SVH
`define PAM_PARAMS_SVH
`define PAM_OFS_UPPER     4'h0
`define PAM_OFS_FIRST     4'h4
`define PAM_OFS_SECOND    4'h8
`define PAM_RST_ZERO      16'h0000
`define PAM_POS_DBG_BIT   10
`define PAM_POS_ROM_UPPER 5
`define PAM_POS_ROM_SEC   13
`define PAM_FIRST_BASE_PIN 8
`define PAM_MD_GPIO       3'h0
`define PAM_MD_1          3'h1
`define PAM_MD_2          3'h2
`define PAM_MD_3          3'h3
`define PAM_MD_4          3'h4
`define PAM_MD_5          3'h5
`define PAM_MD_6          3'h6
`endif

// ==== hdl/pam_pkg.sv ====
// types of the port a low pin function select block
// assumes pam_params.svh for all numbers
package pam_pkg;
  typedef logic [2:0]             pam_code_t;
  typedef pam_code_t [10:0]       pam_modes_t;
  typedef struct packed {
    logic [15:0] upper;
    logic [15:0] first;
    logic [15:0] second;
    logic        ack;
    logic [31:0] rdata;
  } pam_regs_t;
  typedef struct packed {
    logic [10:0] pad_out;
    logic [10:0] pad_oe;
    logic [10:0] gpio_in;
    logic [3:0]  irq;
    logic [6:0]  poe;
    logic [3:0]  tclk;
    logic        bus_wait;
    logic        s2_clk;
    logic        s2_rxd;
    logic        s3_clk;
    logic        s3_rxd;
    logic        pulse_in;
    logic        test_clk;
  } pam_route_t;
endpackage

// ==== hdl/pam_cfg_if.sv ====
// interface carrying the three select registers to the field splitter
// assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
interface pam_cfg_if;
  logic [15:0] upper;
  logic [15:0] first;
  logic [15:0] second;
  modport regs (output upper, output first, output second);
  modport user (input upper, input first, input second);
endinterface
`default_nettype wire

// ==== hdl/pam_regs.sv ====
// avalon-mm slave holding the three 16-bit select registers
// assumes straps are stable while srst is high
`timescale 1ns/1ps
`default_nettype none
`include "pam_params.svh"
module pam_regs (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // mode straps
  input  wire logic        debug_mode_pin_n,
  input  wire logic        rom_disabled_8bit_mode,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // register image
  pam_cfg_if.regs          cfg
);
  pam_pkg::pam_regs_t r_reg, r_next;
  logic req;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] d,
                                          input logic [1:0] be);
    merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction

  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~r_reg.ack;
  assign avs_readdata    = r_reg.rdata;
  assign cfg.upper       = r_reg.upper;
  assign cfg.first       = r_reg.first;
  assign cfg.second      = r_reg.second;

  always_comb begin
    r_next     = r_reg;
    r_next.ack = req & ~r_reg.ack;
    if (avs_read && !r_reg.ack) begin
      unique case (avs_address & 4'hc)
        `PAM_OFS_UPPER:  r_next.rdata = {16'h0000, r_reg.upper};
        `PAM_OFS_FIRST:  r_next.rdata = {16'h0000, r_reg.first};
        `PAM_OFS_SECOND: r_next.rdata = {16'h0000, r_reg.second};
        default:         r_next.rdata = 32'h0000_0000;
      endcase
    end
    if (avs_write && r_reg.ack) begin
      unique case (avs_address & 4'hc)
        `PAM_OFS_UPPER:  r_next.upper  = merge16(r_reg.upper, avs_writedata[15:0],
                                                 avs_byteenable[1:0]);
        `PAM_OFS_FIRST:  r_next.first  = merge16(r_reg.first, avs_writedata[15:0],
                                                 avs_byteenable[1:0]);
        `PAM_OFS_SECOND: r_next.second = merge16(r_reg.second, avs_writedata[15:0],
                                                 avs_byteenable[1:0]);
        default: ;
      endcase
    end
    if (srst) begin
      // straps caught by the clocked process; reset is synchronous
      r_next        = '0;
      r_next.upper  = `PAM_RST_ZERO;
      r_next.first  = `PAM_RST_ZERO;
      r_next.second = `PAM_RST_ZERO;
      r_next.upper[`PAM_POS_DBG_BIT] = ~debug_mode_pin_n;
      r_next.upper[`PAM_POS_ROM_UPPER:0] = {6{rom_disabled_8bit_mode}};
      r_next.second[`PAM_POS_ROM_SEC -: 2] = {2{rom_disabled_8bit_mode}};
    end
  end

  always_ff @(posedge clk) begin
    r_reg <= r_next;
  end

  a_wait_bounded: assert property (@(posedge clk) disable iff (srst)
    req |-> ##[0:1] !avs_waitrequest) else $error("waitrequest held too long");
endmodule // pam_regs
`default_nettype wire

// ==== hdl/pam_mode_fields.sv ====
// splits the register image into one 3-bit code per pin
// assumes pins 8..10 low bits in the first register, 0..7 in the second
`timescale 1ns/1ps
`default_nettype none
`include "pam_params.svh"
module pam_mode_fields (
  // register image
  pam_cfg_if.user               cfg,
  // per-pin codes
  output pam_pkg::pam_modes_t   modes
);
  function automatic pam_pkg::pam_code_t field(input logic [15:0] up, input logic [15:0] lo,
                                               input int pin, input int slot);
    field = {up[pin], lo[2*slot+1], lo[2*slot]};
  endfunction

  always_comb begin
    for (int p = 0; p < 11; p++) begin
      if (p >= `PAM_FIRST_BASE_PIN) begin
        modes[p] = field(cfg.upper, cfg.first, p, p - `PAM_FIRST_BASE_PIN);
      end else begin
        modes[p] = field(cfg.upper, cfg.second, p, p);
      end
    end
  end
endmodule // pam_mode_fields
`default_nettype wire

// ==== hdl/pam_pin_mux.sv ====
// top of the port a pins 0..10 function select multiplexer
// assumes the direction register and peripherals live outside, all on clk
`timescale 1ns/1ps
`default_nettype none
`include "pam_params.svh"
module pam_pin_mux (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // mode straps
  input  wire logic        debug_mode_pin_n,
  input  wire logic        rom_disabled_8bit_mode,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // pads
  input  wire logic [10:0] pad_in,
  output logic [10:0]      pad_out,
  output logic [10:0]      pad_oe,
  // general purpose port
  input  wire logic [10:0] port_a_direction_reg,
  input  wire logic [10:0] gpio_out_data,
  output logic [10:0]      gpio_in_data,
  // external bus controller
  input  wire logic        chip_select_zero_out,
  input  wire logic        read_strobe_out,
  input  wire logic [5:0]  address_out,
  output logic             bus_wait_req_in,
  // timers and interrupts
  output logic [3:0]       timer_ext_clock_in,
  output logic [3:0]       ext_interrupt_in,
  output logic [6:0]       output_disable_req_in,
  // serial channels
  input  wire logic        serial2_clock_io_out,
  output logic             serial2_clock_io_in,
  input  wire logic        serial2_txd_out,
  output logic             serial2_rxd_in,
  input  wire logic        serial3_clock_io_out,
  output logic             serial3_clock_io_in,
  input  wire logic        serial3_txd_out,
  output logic             serial3_rxd_in,
  // motor timer and debug
  input  wire logic        motor_timer_pulse_io_out,
  output logic             motor_timer_pulse_io_in,
  output logic             debug_test_clock_in
);
  pam_pkg::pam_route_t r_reg, r_next;
  pam_pkg::pam_modes_t md;
  pam_cfg_if           cfg ();

  pam_regs u_regs (
    .clk                    (clk),
    .srst                   (srst),
    .debug_mode_pin_n       (debug_mode_pin_n),
    .rom_disabled_8bit_mode (rom_disabled_8bit_mode),
    .avs_address            (avs_address),
    .avs_read               (avs_read),
    .avs_write              (avs_write),
    .avs_writedata          (avs_writedata),
    .avs_byteenable         (avs_byteenable),
    .avs_readdata           (avs_readdata),
    .avs_waitrequest        (avs_waitrequest),
    .cfg                    (cfg.regs)
  );

  pam_mode_fields u_fields (
    .cfg   (cfg.user),
    .modes (md)
  );

  // every pad output is registered: one cycle of latency buys glitch-free pads
  always_comb begin
    r_next          = '0;
    r_next.gpio_in  = pad_in;
    r_next.pad_out  = gpio_out_data;
    r_next.pad_oe   = port_a_direction_reg;

    // pin 10
    unique case (md[10])
      `PAM_MD_GPIO: ;
      `PAM_MD_1: begin
        r_next.pad_out[10] = chip_select_zero_out;
        r_next.pad_oe[10]  = 1'b1;
      end
      `PAM_MD_2: begin
        r_next.pad_out[10] = read_strobe_out;
        r_next.pad_oe[10]  = 1'b1;
      end
      `PAM_MD_4: begin
        // only valid on the flash variant; mask parts must not select it
        r_next.pad_oe[10]  = 1'b0;
        r_next.test_clk    = pad_in[10];
      end
      `PAM_MD_5: begin
        r_next.pad_out[10] = serial2_clock_io_out;
        r_next.s2_clk      = pad_in[10];
      end
      default: r_next.pad_oe[10] = 1'b0;
    endcase

    // pin 9
    unique case (md[9])
      `PAM_MD_GPIO: ;
      `PAM_MD_1: begin
        r_next.pad_oe[9] = 1'b0;
        r_next.tclk[3]   = pad_in[9];
      end
      `PAM_MD_2: begin
        r_next.pad_oe[9] = 1'b0;
        r_next.irq[3]    = pad_in[9];
      end
      `PAM_MD_5: begin
        r_next.pad_out[9] = serial3_txd_out;
        r_next.pad_oe[9]  = 1'b1;
      end
      default: r_next.pad_oe[9] = 1'b0;
    endcase

    // pin 8
    unique case (md[8])
      `PAM_MD_GPIO: ;
      `PAM_MD_1: begin
        r_next.pad_oe[8] = 1'b0;
        r_next.tclk[2]   = pad_in[8];
      end
      `PAM_MD_2: begin
        r_next.pad_oe[8] = 1'b0;
        r_next.irq[2]    = pad_in[8];
      end
      `PAM_MD_5: begin
        r_next.pad_oe[8] = 1'b0;
        r_next.s3_rxd    = pad_in[8];
      end
      default: r_next.pad_oe[8] = 1'b0;
    endcase

    // pin 7
    unique case (md[7])
      `PAM_MD_GPIO: ;
      `PAM_MD_1: begin
        r_next.pad_oe[7] = 1'b0;
        r_next.tclk[1]   = pad_in[7];
      end
      `PAM_MD_3: begin
        r_next.pad_oe[7] = 1'b0;
        r_next.bus_wait  = pad_in[7];
      end
      `PAM_MD_5: begin
        r_next.pad_out[7] = serial2_txd_out;
        r_next.pad_oe[7]  = 1'b1;
      end
      default: r_next.pad_oe[7] = 1'b0;
    endcase

    // pin 6
    unique case (md[6])
      `PAM_MD_GPIO: ;
      `PAM_MD_1: begin
        r_next.pad_oe[6] = 1'b0;
        r_next.tclk[0]   = pad_in[6];
      end
      `PAM_MD_3: begin
        r_next.pad_out[6] = read_strobe_out;
        r_next.pad_oe[6]  = 1'b1;
      end
      `PAM_MD_5: begin
        r_next.pad_oe[6] = 1'b0;
        r_next.s2_rxd    = pad_in[6];
      end
      default: r_next.pad_oe[6] = 1'b0;
    endcase

    // pin 5
    unique case (md[5])
      `PAM_MD_GPIO: ;
      `PAM_MD_3: begin
        r_next.pad_oe[5] = 1'b0;
        r_next.irq[1]    = pad_in[5];
      end
      `PAM_MD_4: begin
        r_next.pad_out[5] = address_out[5];
        r_next.pad_oe[5]  = 1'b1;
      end
      `PAM_MD_5: begin
        r_next.pad_oe[5] = 1'b0;
        r_next.poe[6]    = pad_in[5];
      end
      `PAM_MD_6: begin
        r_next.pad_out[5] = serial3_clock_io_out;
        r_next.s3_clk     = pad_in[5];
      end
      default: r_next.pad_oe[5] = 1'b0;
    endcase

    // pin 4
    unique case (md[4])
      `PAM_MD_GPIO: ;
      `PAM_MD_4: begin
        r_next.pad_out[4] = address_out[4];
        r_next.pad_oe[4]  = 1'b1;
      end
      `PAM_MD_5: begin
        r_next.pad_oe[4] = 1'b0;
        r_next.poe[5]    = pad_in[4];
      end
      `PAM_MD_6: begin
        r_next.pad_out[4] = serial3_txd_out;
        r_next.pad_oe[4]  = 1'b1;
      end
      default: r_next.pad_oe[4] = 1'b0;
    endcase

    // pin 3
    unique case (md[3])
      `PAM_MD_GPIO: ;
      `PAM_MD_4: begin
        r_next.pad_out[3] = address_out[3];
        r_next.pad_oe[3]  = 1'b1;
      end
      `PAM_MD_5: begin
        r_next.pad_oe[3] = 1'b0;
        r_next.poe[4]    = pad_in[3];
      end
      `PAM_MD_6: begin
        r_next.pad_oe[3] = 1'b0;
        r_next.s3_rxd    = r_next.s3_rxd | pad_in[3];
      end
      default: r_next.pad_oe[3] = 1'b0;
    endcase

    // pin 2
    unique case (md[2])
      `PAM_MD_GPIO: ;
      `PAM_MD_3: begin
        r_next.pad_oe[2] = 1'b0;
        r_next.irq[0]    = pad_in[2];
      end
      `PAM_MD_4: begin
        r_next.pad_out[2] = address_out[2];
        r_next.pad_oe[2]  = 1'b1;
      end
      `PAM_MD_5: begin
        r_next.pad_out[2] = motor_timer_pulse_io_out;
        r_next.pulse_in   = pad_in[2];
      end
      `PAM_MD_6: begin
        r_next.pad_out[2] = serial2_clock_io_out;
        r_next.s2_clk     = r_next.s2_clk | pad_in[2];
      end
      default: r_next.pad_oe[2] = 1'b0;
    endcase

    // pin 1
    unique case (md[1])
      `PAM_MD_GPIO: ;
      `PAM_MD_4: begin
        r_next.pad_out[1] = address_out[1];
        r_next.pad_oe[1]  = 1'b1;
      end
      `PAM_MD_5: begin
        r_next.pad_oe[1] = 1'b0;
        r_next.poe[1]    = pad_in[1];
      end
      `PAM_MD_6: begin
        r_next.pad_out[1] = serial2_txd_out;
        r_next.pad_oe[1]  = 1'b1;
      end
      default: r_next.pad_oe[1] = 1'b0;
    endcase

    // pin 0
    unique case (md[0])
      `PAM_MD_GPIO: ;
      `PAM_MD_4: begin
        r_next.pad_out[0] = address_out[0];
        r_next.pad_oe[0]  = 1'b1;
      end
      `PAM_MD_5: begin
        r_next.pad_oe[0] = 1'b0;
        r_next.poe[0]    = pad_in[0];
      end
      `PAM_MD_6: begin
        r_next.pad_oe[0] = 1'b0;
        r_next.s2_rxd    = r_next.s2_rxd | pad_in[0];
      end
      default: r_next.pad_oe[0] = 1'b0;
    endcase

    if (srst) begin
      r_next = '0;
    end
  end

  always_ff @(posedge clk) begin
    r_reg <= r_next;
  end

  assign pad_out                 = r_reg.pad_out;
  assign pad_oe                  = r_reg.pad_oe;
  assign gpio_in_data            = r_reg.gpio_in;
  assign bus_wait_req_in         = r_reg.bus_wait;
  assign timer_ext_clock_in      = r_reg.tclk;
  assign ext_interrupt_in        = r_reg.irq;
  assign output_disable_req_in   = r_reg.poe;
  assign serial2_clock_io_in     = r_reg.s2_clk;
  assign serial2_rxd_in          = r_reg.s2_rxd;
  assign serial3_clock_io_in     = r_reg.s3_clk;
  assign serial3_rxd_in          = r_reg.s3_rxd;
  assign motor_timer_pulse_io_in = r_reg.pulse_in;
  assign debug_test_clock_in     = r_reg.test_clk;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_cs0_held;
    md[10] == `PAM_MD_1 ##1 md[10] == `PAM_MD_1;
  endsequence

  a_pin10_cs0: assert property (s_cs0_held |-> pad_oe[10]
    && pad_out[10] == $past(chip_select_zero_out)) else $error("pin10 cs0 route");
  a_pin10_tck: assert property (!srst && md[10] == `PAM_MD_4 |=> !pad_oe[10]
    && debug_test_clock_in == $past(pad_in[10])) else $error("pin10 test clock");
  a_pin9_ext_interrupt3_in: assert property (md[9] == `PAM_MD_2 |=>
    ext_interrupt_in[3] == $past(pad_in[9]) && !pad_oe[9]) else $error("pin9 irq");
  a_pin8_serial3_rxd_in: assert property (md[8] == `PAM_MD_5 && md[3] != `PAM_MD_6 |=>
    serial3_rxd_in == $past(pad_in[8])) else $error("pin8 serial3_rxd_in");
  a_pin7_wait: assert property (md[7] == `PAM_MD_3 |=>
    bus_wait_req_in == $past(pad_in[7])) else $error("pin7 wait");
  a_pin6_rd: assert property (!srst && md[6] == `PAM_MD_3 |=> pad_oe[6]
    && pad_out[6] == $past(read_strobe_out)) else $error("pin6 read strobe");
  a_pin5_output_disable_req6_in: assert property (md[5] == `PAM_MD_5 |=>
    output_disable_req_in[6] == $past(pad_in[5])) else $error("pin5 disable");
  a_pin4_serial3_txd_out: assert property (md[4] == `PAM_MD_6 |=> pad_oe[4]
    && pad_out[4] == $past(serial3_txd_out)) else $error("pin4 serial3_txd_out");
  a_pin3_addr: assert property (!srst && md[3] == `PAM_MD_4 |=>
    pad_out[3] == $past(address_out[3])) else $error("pin3 address");
  a_pin2_pulse: assert property (md[2] == `PAM_MD_5 |=>
    pad_oe[2] == $past(port_a_direction_reg[2])) else $error("pin2 pulse dir");
  a_pin1_serial2_txd_out: assert property (md[1] == `PAM_MD_6 |=> pad_oe[1]
    && pad_out[1] == $past(serial2_txd_out)) else $error("pin1 serial2_txd_out");
  a_pin0_addr: assert property (!srst && md[0] == `PAM_MD_4 |=> pad_oe[0]
    && pad_out[0] == $past(address_out[0])) else $error("pin0 address");
  a_gpio_dir: assert property (!srst && md[0] == `PAM_MD_GPIO |=>
    pad_oe[0] == $past(port_a_direction_reg[0])) else $error("gpio direction");
  a_dbg_reset: assert property (disable iff (1'b0) srst && !debug_mode_pin_n
    |=> md[10] == `PAM_MD_4) else $error("debug reset value");
  a_rom_reset: assert property (disable iff (1'b0) srst && rom_disabled_8bit_mode
    |=> md[6] == `PAM_MD_3 && md[0] == `PAM_MD_4) else $error("rom-off reset value");
  a_gpio_reset: assert property (disable iff (1'b0)
    srst && debug_mode_pin_n && !rom_disabled_8bit_mode |=> md == '0)
    else $error("gpio reset value");
endmodule // pam_pin_mux
`default_nettype wire

// ==== dv/pam_periph_model.sv ====
// partner model: on-chip peripherals and the board side of the port a pads
// assumes the bench picks the peripheral output level and the board pad drive
`timescale 1ns/1ps
`default_nettype none
module pam_periph_model (
  // bench controls
  input  wire logic [12:0] level,
  input  wire logic [10:0] ext_drive,
  // pads
  input  wire logic [10:0] pad_out,
  input  wire logic [10:0] pad_oe,
  output logic [10:0]      pad_in,
  // peripheral outputs: pulse, s3 txd, s3 clk, s2 txd, s2 clk, addr, rd, cs
  output logic [12:0]      periph_out
);
  // board always drives where the mux releases, so no stale level on a pad
  assign pad_in     = (pad_oe & pad_out) | (~pad_oe & ext_drive);
  // one level per source, so a swapped route shows up as a wrong pad level
  assign periph_out = level;
endmodule // pam_periph_model
`default_nettype wire

// ==== dv/tb_port_a_low_pin_function_select.sv ====
// testbench for the port a pins 0..10 function select multiplexer
// assumes pam_pin_mux on one 125 mhz clock and the peripheral model beside it
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("mismatch %s expected %0h seen %0h", n, e, g); \
  end \
end
module tb_port_a_low_pin_function_select;
  logic        clk, srst, dbg_n, rom8, av_rd, av_wr, av_wait;
  logic        bw, s2c, s2r, s3c, s3r, pls, tck;
  logic [3:0]  av_a, tclk, irq;
  logic [6:0]  poe;
  logic [31:0] av_wd, av_q, q;
  logic [10:0] pad_in, pad_out, pad_oe, dir, gpo, gpi, ext;
  logic [12:0] po, lvl;
  logic [21:0] pin_in;
  logic [15:0] sh [3];
  int          mismatches, samples_checked, cycles;
  assign pin_in = {tck, pls, s3r, s3c, s2r, s2c, bw, poe, irq, tclk};
  pam_pin_mux uut (
    .clk(clk), .srst(srst), .debug_mode_pin_n(dbg_n), .rom_disabled_8bit_mode(rom8),
    .avs_address(av_a), .avs_read(av_rd), .avs_write(av_wr), .avs_writedata(av_wd),
    .avs_byteenable(4'h3), .avs_readdata(av_q), .avs_waitrequest(av_wait),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .port_a_direction_reg(dir), .gpio_out_data(gpo), .gpio_in_data(gpi),
    .chip_select_zero_out(po[0]), .read_strobe_out(po[1]), .address_out(po[7:2]),
    .bus_wait_req_in(bw), .timer_ext_clock_in(tclk), .ext_interrupt_in(irq),
    .output_disable_req_in(poe), .serial2_clock_io_out(po[8]), .serial2_clock_io_in(s2c),
    .serial2_txd_out(po[9]), .serial2_rxd_in(s2r), .serial3_clock_io_out(po[10]),
    .serial3_clock_io_in(s3c), .serial3_txd_out(po[11]), .serial3_rxd_in(s3r),
    .motor_timer_pulse_io_out(po[12]), .motor_timer_pulse_io_in(pls),
    .debug_test_clock_in(tck));
  pam_periph_model pm (.level(lvl), .ext_drive(ext), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_in(pad_in), .periph_out(po));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // generous ceiling: the whole run needs some 1200 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      mismatches++;
      results();
    end
  end
  // request held until waitrequest is seen low, then released for one edge
  task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [15:0] d);
    av_a <= a;
    av_wr <= wr;
    av_rd <= ~wr;
    av_wd <= {16'h0000, d};
    do @(posedge clk); while (av_wait !== 1'b0);
    q = av_q;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic settle;
    repeat (3) @(posedge clk);
  endtask
  task automatic write_all;
    for (int i = 0; i < 3; i++) av_xfer(1'b1, 4'(i * 4), sh[i]);
  endtask
  task automatic chk_regs(input string n);
    for (int i = 0; i < 3; i++) begin
      av_xfer(1'b0, 4'(i * 4), 16'h0000);
      `CHK(n, {16'h0000, sh[i]}, q)
    end
  endtask
  task automatic do_reset(input logic d, input logic r);
    dbg_n <= d;
    rom8 <= r;
    srst <= 1'b1;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    sh[0] = {5'h00, ~d, 4'h0, {6{r}}};
    sh[1] = 16'h0000;
    sh[2] = {2'h0, {2{r}}, 12'h000};
  endtask
  task automatic set_mode(input int pin, input logic [2:0] c);
    sh[0][pin] = c[2];
    if (pin >= 8) sh[1][(pin - 8) * 2 +: 2] = c[1:0];
    else sh[2][pin * 2 +: 2] = c[1:0];
    write_all();
  endtask
  // which peripheral output a pin function forwards, one-hot on the model outputs
  function automatic logic [12:0] src_sel(input int pin, input logic [2:0] c);
    if (c == 3'h4 && pin < 6) return 13'h0004 << pin;
    case (pin * 8 + c)
      81: return 13'h0001;
      82: return 13'h0002;
      85: return 13'h0100;
      77: return 13'h0800;
      61: return 13'h0200;
      51: return 13'h0002;
      46: return 13'h0400;
      38: return 13'h0800;
      21: return 13'h1000;
      22: return 13'h0100;
      14: return 13'h0200;
      default: return 13'h0000;
    endcase
  endfunction
  // kind 0 output function, 1 input function, 2 direction-controlled i/o
  // direction bit toggles for every kind: fixed functions must ignore it
  task automatic try_mode(input int pin, input logic [2:0] c, input int kind, input int idx);
    logic o;
    set_mode(pin, c);
    for (int k = 0; k < 4; k++) begin
      o = (kind == 0) || (kind == 2 && k >= 2);
      dir <= k[1] ? 11'h001 << pin : 11'h000;
      lvl <= k[0] ? src_sel(pin, c) : 13'h0000;
      ext <= k[0] ? 11'h001 << pin : 11'h000;
      settle();
      `CHK("pad oe", o, pad_oe[pin])
      if (o) `CHK("pad out", k[0], pad_out[pin]) else `CHK("periph in", k[0], pin_in[idx])
    end
    set_mode(pin, 3'h0);
  endtask
  initial begin
    {srst, dbg_n, rom8, av_rd, av_wr} = 5'h18;
    {av_a, av_wd, dir, gpo, ext, lvl} = '0;
    {mismatches, samples_checked, cycles} = '0;
    do_reset(1'b0, 1'b1);
    chk_regs("strap reset");
    settle();
    `CHK("strap oe", 11'h07f, pad_oe)
    $display("test straps done");
    do_reset(1'b1, 1'b0);
    chk_regs("plain reset");
    sh[0] = 16'h5a3c;
    sh[1] = 16'hc3a5;
    sh[2] = 16'h9669;
    write_all();
    chk_regs("readback");
    sh = '{default: 16'h0000};
    write_all();
    av_xfer(1'b1, 4'hc, 16'hffff);
    av_xfer(1'b0, 4'hc, 16'h0000);
    `CHK("unmapped", 32'h0000_0000, q)
    chk_regs("after unmapped");
    $display("test registers done");
    dir <= 11'h7ff;
    gpo <= 11'h5a5;
    settle();
    `CHK("gpio out", 11'h5a5, pad_out)
    `CHK("gpio oe", 11'h7ff, pad_oe)
    set_mode(10, 3'h3);
    settle();
    `CHK("prohibited oe", 1'b0, pad_oe[10])
    set_mode(10, 3'h0);
    dir <= 11'h000;
    ext <= 11'h2b6;
    settle();
    `CHK("gpio in", 11'h2b6, gpi)
    `CHK("gpio in oe", 11'h000, pad_oe)
    $display("test gpio done");
    try_mode(10, 3'h1, 0, 0);
    try_mode(10, 3'h2, 0, 0);
    try_mode(10, 3'h4, 1, 21);
    try_mode(10, 3'h5, 2, 16);
    try_mode(9, 3'h1, 1, 3);
    try_mode(9, 3'h2, 1, 7);
    try_mode(9, 3'h5, 0, 0);
    try_mode(8, 3'h1, 1, 2);
    try_mode(8, 3'h2, 1, 6);
    try_mode(8, 3'h5, 1, 19);
    try_mode(7, 3'h1, 1, 1);
    try_mode(7, 3'h3, 1, 15);
    try_mode(7, 3'h5, 0, 0);
    try_mode(6, 3'h1, 1, 0);
    try_mode(6, 3'h3, 0, 0);
    try_mode(6, 3'h5, 1, 17);
    try_mode(5, 3'h3, 1, 5);
    try_mode(5, 3'h4, 0, 0);
    try_mode(5, 3'h5, 1, 14);
    try_mode(5, 3'h6, 2, 18);
    try_mode(4, 3'h4, 0, 0);
    try_mode(4, 3'h5, 1, 13);
    try_mode(4, 3'h6, 0, 0);
    try_mode(3, 3'h4, 0, 0);
    try_mode(3, 3'h5, 1, 12);
    try_mode(3, 3'h6, 1, 19);
    try_mode(2, 3'h3, 1, 4);
    try_mode(2, 3'h4, 0, 0);
    try_mode(2, 3'h5, 2, 20);
    try_mode(2, 3'h6, 2, 16);
    try_mode(1, 3'h4, 0, 0);
    try_mode(1, 3'h5, 1, 9);
    try_mode(1, 3'h6, 0, 0);
    try_mode(0, 3'h4, 0, 0);
    try_mode(0, 3'h5, 1, 8);
    try_mode(0, 3'h6, 1, 17);
    $display("test functions done");
    results();
  end
endmodule // tb_port_a_low_pin_function_select
`undef CHK
`default_nettype wire
